// ==== pkg/radio_spi_defs.svh ====
/*
 * Constants of the radio command port: command decode, register layout,
 * buffer address space and receive status layout.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef RADIO_SPI_DEFS_SVH
`define RADIO_SPI_DEFS_SVH
// Functional notes
// R1 - Register command: bit7 one, bit6 write, address
// R2 - Register read data returned in second byte
// R3 - Register write data stored from second byte
// R4 - Master releases select after data byte
// R5 - First returned byte is the status byte
// R6 - Buffer access starts counter at zero
// R7 - Buffer read 001, write 011, low bits reserved
// R8 - Buffer read: length, payload, quality, energy, status
// R9 - Buffer write: length then payload, all stored
// R10 - Frame length never above 127
// R11 - Each buffer data byte advances counter
// R12 - Buffer read abort by select, no effect
// R13 - Buffer replaced by received frame or write
// R14 - Buffer access violation raises underrun event 6
// R15 - Receive status read-only, checksum bit7, result field
// R16 - Memory command then start address byte
// R17 - Memory data moves from third byte onward
// R18 - Memory map: buffer 0x00-0x7f, cipher 0x82-0x94
// R19 - Memory counter increments after every byte
// R20 - Memory mode never raises underrun event
// R21 - Master stays inside memory buffer size
// R22 - Status byte source chosen in control register
// R23 - Memory read of length has no side effect
// R24 - Select field 0 zero, 1 state, 2 strength, 3 events
// R25 - Sample on rising, shift on falling, MSB first
// R26 - Master ignores don't-care returned bytes
// R27 - Reserved low command bits ignored
`define CMD_REG_BIT 7
`define CMD_WR_BIT 6
`define CMD_KIND_BIT 5
`define CTRL_ONE_ADDR 6'h04
`define STAT_SEL_HI 3
`define STAT_SEL_LO 2
`define STAT_SEL_ZERO 2'h0
`define STAT_SEL_STATE 2'h1
`define STAT_SEL_RSSI 2'h2
`define STAT_SEL_IRQ 2'h3
`define REG_COUNT 64
`define FB_SIZE 128
`define FB_LAST 8'h7f
`define FRAME_MAX 8'h7f
`define CIPH_FIRST 8'h82
`define CIPH_LAST 8'h94
`define CIPH_SIZE 19
`define RXST_RESET 8'h00
`define UNDERRUN_IRQ 6
`endif

// ==== pkg/radio_spi_pkg.sv ====
/*
 * Types of the radio command port.
 * Assumes the constants header is on the include path.
 */
package radio_spi_pkg;
`include "radio_spi_defs.svh"
typedef enum logic [2:0] {
    MODE_IDLE, MODE_REG, MODE_FB_RD, MODE_FB_WR, MODE_SRAM_RD, MODE_SRAM_WR
} access_mode_t;
typedef struct packed {
    logic [7:0] transceiver_state;
    logic [7:0] signal_strength;
    logic [7:0] irq_status;
} radio_status_t;
typedef struct packed {
    logic [7:0] lqi;
    logic [7:0] energy;
    logic crc_valid;
    logic [2:0] transaction_result_field;
} rx_quality_t;
endpackage

// ==== logic/radio_spi_access.sv ====
/*
 * Command port of the radio: serial slave sampled on clk_in, register
 * file, frame buffer, cipher memory and receive byte FIFO.
 * Assumes serial pins are asynchronous to clk_in and more than six
 * times slower; radio side inputs are synchronous to clk_in.
 */
`timescale 1ns/1ps
`include "radio_spi_defs.svh"

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
        logic full;
        logic empty;
    } fifo_state_t;
    fifo_state_t s;
    fifo_state_t next_s;
    logic push;
    logic pop;

    always_comb begin
        next_s = s;
        push = in_valid_in && !s.full;
        pop = out_ready_in && !s.empty;
        if (push) begin
            next_s.mem[s.wr] = in_data_in;
            next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
        next_s.full = (next_s.count == (AW+1)'(DEPTH));
        next_s.empty = (next_s.count == '0);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.empty <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready_out = !s.full;
    assign out_valid_out = !s.empty;
    assign out_data_out = s.mem[s.rd];
endmodule

module radio_spi_access
    import radio_spi_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic sclk_in,
    input wire logic sel_b_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire radio_status_t radio_status_in,
    input wire logic rx_start_in,
    input wire logic rx_byte_valid_in,
    input wire logic [7:0] rx_byte_in,
    output logic rx_byte_ready_out,
    input wire logic rx_done_in,
    input wire rx_quality_t rx_quality_in,
    output logic [7:0] ctrl_one_out,
    output logic [7:0] irq_event_out
);
    typedef struct packed {
        logic [1:0] sclk_sync;
        logic [1:0] sel_sync;
        logic [1:0] mosi_sync;
        logic sclk_prev;
        logic sel_prev;
        logic active;
        access_mode_t mode;
        logic [5:0] reg_addr;
        logic reg_wr;
        logic [7:0] addr;
        logic [1:0] byte_idx;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sr;
        logic [7:0] tx_sr;
        logic [7:0] tx_next;
        logic load_pending;
        logic [`REG_COUNT-1:0][7:0] regs;
        logic [`FB_SIZE-1:0][7:0] fbuf;
        logic [`CIPH_SIZE-1:0][7:0] ciph;
        logic [7:0] lqi;
        logic [7:0] energy;
        logic [7:0] rx_status;
        logic [7:0] rx_wptr;
        logic rx_active;
        logic [7:0] irq_event;
    } spi_state_t;

    spi_state_t s;
    spi_state_t next_s;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;
    logic byte_done;
    logic [7:0] byte_in;
    logic [7:0] status_now;
    logic drain_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;

    // -----------------------------------------------------------------
    // Buffer and memory read decode
    // -----------------------------------------------------------------
    // R8 - read sequence order
    function automatic logic [7:0] fb_byte(spi_state_t st, logic [7:0] a);
        logic [7:0] len;
        // R10 - length limited to 127
        len = {1'b0, st.fbuf[0][6:0]};
        if (a <= len) begin
            fb_byte = st.fbuf[a[6:0]];
        end else if (a == len + 8'h01) begin
            fb_byte = st.lqi;
        end else if (a == len + 8'h02) begin
            fb_byte = st.energy;
        end else if (a == len + 8'h03) begin
            fb_byte = st.rx_status;
        end else begin
            fb_byte = 8'h00;
        end
    endfunction

    // R18 - memory address map
    function automatic logic [7:0] sram_byte(spi_state_t st, logic [7:0] a);
        if (a <= `FB_LAST) begin
            sram_byte = st.fbuf[a[6:0]];
        end else if (a >= `CIPH_FIRST && a <= `CIPH_LAST) begin
            sram_byte = st.ciph[5'(a - `CIPH_FIRST)];
        end else begin
            sram_byte = 8'h00;
        end
    endfunction

    // -----------------------------------------------------------------
    // Receive byte FIFO
    // -----------------------------------------------------------------
    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(rx_byte_valid_in),
        .in_data_in(rx_byte_in),
        .in_ready_out(rx_byte_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(drain_ready)
    );

    // -----------------------------------------------------------------
    // Edge detection and status select
    // -----------------------------------------------------------------
    assign sclk_rise = s.sclk_sync[1] && !s.sclk_prev && s.active;
    assign sclk_fall = !s.sclk_sync[1] && s.sclk_prev && s.active;
    assign sel_fall = !s.sel_sync[1] && s.sel_prev;
    assign sel_rise = s.sel_sync[1] && !s.sel_prev;
    assign byte_done = sclk_rise && (s.bit_cnt == 3'h7);
    assign byte_in = {s.rx_sr[6:0], s.mosi_sync[1]};
    // Serial buffer writes win over the radio for the buffer port
    assign drain_ready = !(byte_done &&
        (s.mode == MODE_FB_WR || s.mode == MODE_SRAM_WR));

    // R22 - select source of status byte
    always_comb begin
        unique case (s.regs[`CTRL_ONE_ADDR][`STAT_SEL_HI:`STAT_SEL_LO])
            // R24 - select field encoding
            `STAT_SEL_ZERO: status_now = 8'h00;
            `STAT_SEL_STATE: status_now = radio_status_in.transceiver_state;
            `STAT_SEL_RSSI: status_now = radio_status_in.signal_strength;
            `STAT_SEL_IRQ: status_now = radio_status_in.irq_status;
        endcase
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.sclk_sync = {s.sclk_sync[0], sclk_in};
        next_s.sel_sync = {s.sel_sync[0], sel_b_in};
        next_s.mosi_sync = {s.mosi_sync[0], mosi_in};
        next_s.sclk_prev = s.sclk_sync[1];
        next_s.sel_prev = s.sel_sync[1];
        next_s.irq_event = 8'h00;

        // R13 - received frame fills buffer
        if (rx_start_in) begin
            next_s.rx_wptr = 8'h00;
            next_s.rx_active = 1'b1;
        end
        if (fifo_valid && drain_ready && s.rx_wptr <= `FB_LAST) begin
            next_s.fbuf[s.rx_wptr[6:0]] = fifo_data;
            next_s.rx_wptr = s.rx_wptr + 8'h01;
        end
        // R15 - receive status layout
        if (rx_done_in) begin
            next_s.rx_active = 1'b0;
            next_s.lqi = rx_quality_in.lqi;
            next_s.energy = rx_quality_in.energy;
            next_s.rx_status = {rx_quality_in.crc_valid,
                rx_quality_in.transaction_result_field, 4'h0};
        end

        // R12 - release ends access silently
        if (sel_rise) begin
            next_s.active = 1'b0;
            next_s.mode = MODE_IDLE;
        end else if (sel_fall) begin
            // R5 - status byte first
            next_s.active = 1'b1;
            next_s.mode = MODE_IDLE;
            next_s.bit_cnt = 3'h0;
            next_s.byte_idx = 2'h0;
            next_s.tx_sr = status_now;
            next_s.load_pending = 1'b0;
        end else if (sclk_fall) begin
            // R25 - shift out on falling edge
            if (s.load_pending) begin
                next_s.tx_sr = s.tx_next;
                next_s.load_pending = 1'b0;
            end else begin
                next_s.tx_sr = {s.tx_sr[6:0], 1'b0};
            end
        end else if (sclk_rise) begin
            // R25 - sample on rising edge
            next_s.rx_sr = byte_in;
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (byte_done) begin
                next_s.load_pending = 1'b1;
                next_s.tx_next = 8'h00;
                if (s.byte_idx != 2'h3) begin
                    next_s.byte_idx = s.byte_idx + 2'h1;
                end
                if (s.byte_idx == 2'h0) begin
                    // R27 - reserved bits ignored
                    if (byte_in[`CMD_REG_BIT]) begin
                        // R1 - register command decode
                        next_s.mode = MODE_REG;
                        next_s.reg_addr = byte_in[5:0];
                        next_s.reg_wr = byte_in[`CMD_WR_BIT];
                        // R2 - register read data
                        next_s.tx_next = s.regs[byte_in[5:0]];
                    end else if (byte_in[`CMD_KIND_BIT]) begin
                        // R7 - buffer command decode
                        next_s.mode = byte_in[`CMD_WR_BIT] ? MODE_FB_WR
                            : MODE_FB_RD;
                        // R6 - counter starts at zero
                        next_s.addr = 8'h00;
                        if (!byte_in[`CMD_WR_BIT]) begin
                            next_s.tx_next = fb_byte(s, 8'h00);
                            next_s.addr = 8'h01;
                        end
                    end else begin
                        next_s.mode = byte_in[`CMD_WR_BIT] ? MODE_SRAM_WR
                            : MODE_SRAM_RD;
                    end
                end else begin
                    unique case (s.mode)
                        MODE_REG: begin
                            // R3 - register write store
                            if (s.reg_wr && s.byte_idx == 2'h1) begin
                                next_s.regs[s.reg_addr] = byte_in;
                            end
                        end
                        MODE_FB_RD: begin
                            // R11 - read advances counter
                            next_s.tx_next = fb_byte(s, s.addr);
                            next_s.addr = s.addr + 8'h01;
                            // R14 - reading ahead of receiver
                            if (s.rx_active && s.addr >= s.rx_wptr) begin
                                next_s.irq_event[`UNDERRUN_IRQ] = 1'b1;
                            end
                        end
                        MODE_FB_WR: begin
                            // R9 - store length and payload
                            if (s.addr <= `FB_LAST) begin
                                next_s.fbuf[s.addr[6:0]] = byte_in;
                            end else begin
                                // R14 - write past buffer end
                                next_s.irq_event[`UNDERRUN_IRQ] = 1'b1;
                            end
                            // R11 - write advances counter
                            next_s.addr = s.addr + 8'h01;
                        end
                        MODE_SRAM_RD, MODE_SRAM_WR: begin
                            // R20 - no underrun event here
                            // R16 - start address byte
                            if (s.byte_idx == 2'h1) begin
                                next_s.addr = byte_in;
                                if (s.mode == MODE_SRAM_RD) begin
                                    // R23 - plain read, no side effect
                                    next_s.tx_next = sram_byte(s, byte_in);
                                    next_s.addr = byte_in + 8'h01;
                                end
                            end else begin
                                // R17 - data from third byte
                                if (s.mode == MODE_SRAM_RD) begin
                                    next_s.tx_next = sram_byte(s, s.addr);
                                end else if (s.addr <= `FB_LAST) begin
                                    next_s.fbuf[s.addr[6:0]] = byte_in;
                                end else if (s.addr >= `CIPH_FIRST
                                    && s.addr <= `CIPH_LAST) begin
                                    next_s.ciph[5'(s.addr - `CIPH_FIRST)] =
                                        byte_in;
                                end
                                // R19 - step after each byte
                                next_s.addr = s.addr + 8'h01;
                            end
                        end
                        MODE_IDLE: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.sel_sync <= 2'h3;
            s.sel_prev <= 1'b1;
            s.rx_status <= `RXST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign miso_out = s.tx_sr[7];
    assign miso_oe_out = s.active;
    assign ctrl_one_out = s.regs[`CTRL_ONE_ADDR];
    assign irq_event_out = s.irq_event;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence fb_cmd_s;
        byte_done && s.byte_idx == 2'h0 && !byte_in[`CMD_REG_BIT]
            && byte_in[`CMD_KIND_BIT];
    endsequence
    sequence fb_data_s;
        byte_done && s.byte_idx != 2'h0
            && (s.mode == MODE_FB_RD || s.mode == MODE_FB_WR);
    endsequence
    sequence sram_data_s;
        byte_done && s.byte_idx >= 2'h2
            && (s.mode == MODE_SRAM_RD || s.mode == MODE_SRAM_WR);
    endsequence

    status_first_a: assert property ( // R5
        sel_fall |=> s.tx_sr == $past(status_now) && miso_oe_out)
        else $error("status byte not loaded at select");
    reg_read_a: assert property ( // R2
        byte_done && s.byte_idx == 2'h0 && byte_in[`CMD_REG_BIT]
        && !byte_in[`CMD_WR_BIT] |=> s.tx_next == s.regs[s.reg_addr])
        else $error("register read data wrong");
    reg_write_a: assert property ( // R3
        byte_done && s.mode == MODE_REG && s.reg_wr && s.byte_idx == 2'h1
        |=> s.regs[$past(s.reg_addr)] == $past(byte_in))
        else $error("register write not stored");
    fb_start_a: assert property ( // R6
        fb_cmd_s |=> s.addr == ($past(byte_in[`CMD_WR_BIT]) ? 8'h00 : 8'h01))
        else $error("buffer counter not restarted");
    fb_step_a: assert property ( // R11
        fb_data_s |=> s.addr == $past(s.addr) + 8'h01)
        else $error("buffer counter did not advance");
    sram_step_a: assert property ( // R19
        sram_data_s |=> s.addr == $past(s.addr) + 8'h01)
        else $error("memory counter did not advance");
    sram_quiet_a: assert property ( // R20
        sram_data_s |=> !irq_event_out[`UNDERRUN_IRQ])
        else $error("underrun raised in memory mode");
    miso_fall_a: assert property ( // R25
        $changed(s.tx_sr) |-> $past(sclk_fall || sel_fall))
        else $error("output changed off a falling edge");
    abort_a: assert property ( // R12
        sel_rise |=> !miso_oe_out ##1 s.mode == MODE_IDLE)
        else $error("release did not end access");
endmodule

// ==== dv/spi_master_model.sv ====
/*
 * Serial master model for the radio command port.
 * Assumes the bench fills tx_buf, calls run and reads rx_buf.
 */
`timescale 1ns/1ps
module spi_master_model (
    output logic sclk_out,
    output logic sel_b_out,
    output logic mosi_out,
    input wire logic miso_in
);
    logic [7:0] tx_buf [0:15];
    logic [7:0] rx_buf [0:15];

    initial begin
        sclk_out = 1'b0;
        sel_b_out = 1'b1;
        mosi_out = 1'b0;
    end

    // ----------------------------------------
    // Transfer
    // ----------------------------------------
    // whole bytes, in-range addresses
    task automatic run(input int n);
        sel_b_out = 1'b0;
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                mosi_out = tx_buf[b][i];
                #80;
                sclk_out = 1'b1;
                rx_buf[b][i] = miso_in;
                #80;
                sclk_out = 1'b0;
            end
        end
        #80;
        sel_b_out = 1'b1;
        mosi_out = ~mosi_out;
        #120;
    endtask
endmodule

// ==== dv/tb_top.sv ====
/*
 * Bench of the radio command port: registers, status byte, frame
 * buffer, receive path and memory mode through the serial model.
 * Assumes design, package and serial model are compiled first.
 */
`timescale 1ns/1ps
`include "radio_spi_defs.svh"
module tb_top
    import radio_spi_pkg::*;
;
    logic clk_in, rst_b_in, sclk, sel_b, mosi, miso, miso_oe;
    logic rx_start, rx_byte_valid, rx_byte_ready, rx_done;
    logic [7:0] rx_byte, ctrl_one, irq_event;
    radio_status_t radio_status;
    rx_quality_t rx_quality;
    int num_errors, n_tests, cycles, urun_cnt, u;

    radio_spi_access i_radio_spi_access (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk),
        .sel_b_in(sel_b), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .radio_status_in(radio_status),
        .rx_start_in(rx_start), .rx_byte_valid_in(rx_byte_valid),
        .rx_byte_in(rx_byte), .rx_byte_ready_out(rx_byte_ready),
        .rx_done_in(rx_done), .rx_quality_in(rx_quality),
        .ctrl_one_out(ctrl_one), .irq_event_out(irq_event)
    );
    spi_master_model i_spi_master_model (
        .sclk_out(sclk), .sel_b_out(sel_b), .mosi_out(mosi),
        .miso_in(miso)
    );

    // ----------------------------------------
    // Clock, timeout, event counter
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (irq_event[`UNDERRUN_IRQ] === 1'b1)
            urun_cnt++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic xfer(input logic [63:0] v, input int n);
        for (int b = 0; b < 8; b++)
            i_spi_master_model.tx_buf[b] = v[63-8*b -: 8];
        i_spi_master_model.run(n);
    endtask
    function automatic logic [7:0] rx(input int b);
        return i_spi_master_model.rx_buf[b];
    endfunction
    function automatic logic [7:0] stat(input logic [1:0] s);
        case (s)
            `STAT_SEL_STATE: return radio_status.transceiver_state;
            `STAT_SEL_RSSI: return radio_status.signal_strength;
            `STAT_SEL_IRQ: return radio_status.irq_status;
            default: return 8'h00;
        endcase
    endfunction
    task automatic push(input logic [7:0] b);
        @(negedge clk_in);
        rx_byte_valid = 1'b1;
        rx_byte = b;
        for (int w = 0; w < 50 && rx_byte_ready !== 1'b1; w++)
            @(negedge clk_in);
        @(negedge clk_in);
        rx_byte_valid = 1'b0;
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [55:0] fr;
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        urun_cnt = 0;
        radio_status = {8'h08, 8'hc7, 8'h24};
        rx_quality = {8'h5a, 8'h33, 1'b1, 3'h2};
        {rx_start, rx_byte_valid, rx_done, rx_byte} = 11'h000;
        rst_b_in = 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge clk_in);
        xfer({8'h84, 56'h0}, 2);
        chk(rx(0), 8'h00);
        chk(rx(1), 8'h00);
        for (int s = 0; s < 4; s++) begin
            xfer({8'hc4, 4'h0, s[1:0], 2'h0, 48'h0}, 2);
            chk(ctrl_one, {4'h0, s[1:0], 2'h0});
            xfer({8'h84, 56'h0}, 2);
            chk(rx(0), stat(s[1:0]));
            chk(rx(1), {4'h0, s[1:0], 2'h0});
        end
        xfer({8'hc5, 8'h99, 48'h0}, 2);
        chk(ctrl_one, 8'h0c);
        chk({7'h0, miso_oe}, 8'h00);
        $display("Test registers done");
        xfer({8'h7f, 8'h03, 8'ha1, 8'ha2, 8'ha3, 24'h0}, 5);
        xfer({8'h21, 56'h0}, 2);
        chk(rx(1), 8'h03);
        xfer({8'h3f, 56'h0}, 8);
        fr = 56'h03a1a2a3000000;
        for (int b = 1; b < 5; b++)
            chk(rx(b), fr[63-8*b -: 8]);
        chk(rx(7), `RXST_RESET);
        $display("Test frame write done");
        @(negedge clk_in);
        rx_start = 1'b1;
        @(negedge clk_in);
        rx_start = 1'b0;
        push(8'h03);
        u = urun_cnt;
        xfer({8'h1f, 56'h0}, 3);
        chk(rx(2), 8'h03);
        chk(8'(urun_cnt - u), 8'h00);
        xfer({8'h20, 56'h0}, 3);
        chk({7'h0, urun_cnt > u}, 8'h01);
        push(8'hb1);
        push(8'hb2);
        push(8'hb3);
        repeat (8) @(negedge clk_in);
        rx_done = 1'b1;
        @(negedge clk_in);
        rx_done = 1'b0;
        chk({7'h0, rx_byte_ready}, 8'h01);
        xfer({8'h20, 56'h0}, 8);
        fr = 56'h03b1b2b35a33a0;
        for (int b = 1; b < 8; b++)
            chk(rx(b), fr[63-8*b -: 8]);
        $display("Test receive done");
        xfer({8'h5f, 8'h05, 8'h3c, 8'h4d, 32'h0}, 4);
        xfer({8'h00, 8'h03, 48'h0}, 6);
        chk(rx(2), 8'hb3);
        chk(rx(4), 8'h3c);
        chk(rx(5), 8'h4d);
        xfer({8'h40, 8'h93, 8'h6e, 8'h7f, 32'h0}, 4);
        xfer({8'h00, 8'h93, 48'h0}, 4);
        chk(rx(2), 8'h6e);
        chk(rx(3), 8'h7f);
        $display("Test memory done");
        wrap_up();
    end
endmodule
